// File: hdl/ssf_status.sv
// Module: status flags, data registers and APB slave of a serial interface
// Notes on behaviour
// - Transmit end sets when disabled or drained
// - Normal mode: empty-flag clear also clears end
// - Normal mode: DMA data write clears end
// - Receive multiprocessor bit captured, read-only, kept
// - Transmit multiprocessor bit appended to frames
// - Flags take zero writes only, to clear
// - Smart-card select switches flag interpretation
// - Empty flag sets when disabled or loaded
// - Empty flag clears by zero write or DMA
// - Full flag sets on clean reception
// - Full flag clears by zero write or DMA
// - Receiver disable leaves full flag alone
// - Overrun keeps old data, blocks reception
// - Parity/framing error moves data, no full
`timescale 1ns/1ns
module ssf_status
  import ssf_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          tx_load,
  input  wire logic          tx_last_bit,
  output ssf_tx_word_t       tx_word,
  output logic               tx_enable_bit,
  input  wire logic          rx_done,
  input  wire ssf_rx_frame_t rx_frame,
  output logic               rx_enable_bit,
  output logic               rx_blocked,
  input  wire logic          dma_tx_wr,
  input  wire logic [7:0]    dma_tx_data,
  input  wire logic          dma_rx_rd,
  output logic               tx_irq,
  output logic               rx_irq,
  output logic               irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       tx_empty_flag_r;
  logic       rx_full_flag_r;
  logic       overrun_flag_r;
  logic       framing_error_flag_r;
  logic       parity_error_flag_r;
  logic       tx_end_flag_r;
  logic       rx_multiproc_bit_r;
  logic       tx_multiproc_bit_r;
  logic [1:0] serial_control_reg_r;
  logic       smartcard_select_r;
  logic [7:0] tx_data_reg_r;
  logic [7:0] rx_data_reg_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic [7:0] armed_r;
  logic [31:0] prdata_r;

  logic       setup;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       wr_status;
  logic [7:0] status_now;
  logic       clr_tx_empty;
  logic       clr_rx_full;
  logic       clr_overrun;
  logic       clr_framing;
  logic       clr_parity;
  logic       set_tx_empty;
  logic       set_tx_end;
  logic       clr_tx_end;
  logic       rx_accept;
  logic       rx_clean;
  logic       rx_overrun;
  logic       rx_bad;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic ssf_sel(input logic [7:0] a, input logic [7:0] ofs);
    ssf_sel = (a == ofs);
  endfunction : ssf_sel

  // Zero written to a flag that was seen set by a status read
  function automatic logic ssf_zero_clr(input logic w, input logic [31:0] d,
                                        input logic [7:0] arm, input int b);
    ssf_zero_clr = w && !d[b] && arm[b];
  endfunction : ssf_zero_clr

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  assign rd    = psel && penable && !pwrite;
  assign hit   = ssf_sel(paddr, SSF_OFS_STATUS) || ssf_sel(paddr, SSF_OFS_CONTROL) ||
                 ssf_sel(paddr, SSF_OFS_MODE) || ssf_sel(paddr, SSF_OFS_TX_DATA) ||
                 ssf_sel(paddr, SSF_OFS_RX_DATA) || ssf_sel(paddr, SSF_OFS_IRQ_STAT) ||
                 ssf_sel(paddr, SSF_OFS_IRQ_MASK);
  assign wr_status = wr && ssf_sel(paddr, SSF_OFS_STATUS);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  assign status_now = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, framing_error_flag_r,
                       parity_error_flag_r, tx_end_flag_r, rx_multiproc_bit_r, tx_multiproc_bit_r};

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (1'b1)
        ssf_sel(paddr, SSF_OFS_STATUS):   prdata_r <= {24'h00_0000, status_now};
        ssf_sel(paddr, SSF_OFS_CONTROL):  prdata_r <= {30'h0000_0000, serial_control_reg_r};
        ssf_sel(paddr, SSF_OFS_MODE):     prdata_r <= {31'h0000_0000, smartcard_select_r};
        ssf_sel(paddr, SSF_OFS_TX_DATA):  prdata_r <= {24'h00_0000, tx_data_reg_r};
        ssf_sel(paddr, SSF_OFS_RX_DATA):  prdata_r <= {24'h00_0000, rx_data_reg_r};
        ssf_sel(paddr, SSF_OFS_IRQ_STAT): prdata_r <= {28'h000_0000, irq_stat_r};
        ssf_sel(paddr, SSF_OFS_IRQ_MASK): prdata_r <= {28'h000_0000, irq_mask_r};
        default:                          prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read-then-write-zero arming
  // ----------------------------------------------------------------
  // Arming uses the captured read value, so a zero write clears only a flag the CPU saw as 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= SSF_RST_BYTE;
    end else if (wr_status) begin
      armed_r <= SSF_RST_BYTE;
    end else if (rd && ssf_sel(paddr, SSF_OFS_STATUS)) begin
      armed_r <= prdata_r[7:0];
    end
  end

  assign clr_tx_empty = ssf_zero_clr(wr_status, pwdata, armed_r, SSF_B_TX_EMPTY) || dma_tx_wr;
  assign clr_rx_full  = ssf_zero_clr(wr_status, pwdata, armed_r, SSF_B_RX_FULL) || dma_rx_rd;
  assign clr_overrun  = ssf_zero_clr(wr_status, pwdata, armed_r, SSF_B_OVERRUN);
  assign clr_framing  = ssf_zero_clr(wr_status, pwdata, armed_r, SSF_B_FRAMING);
  assign clr_parity   = ssf_zero_clr(wr_status, pwdata, armed_r, SSF_B_PARITY);

  // ----------------------------------------------------------------
  // Control, mode and interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg_r <= 2'h0;
      smartcard_select_r   <= SSF_RST_FLAG;
      irq_mask_r           <= SSF_RST_NIBBLE;
    end else if (wr) begin
      if (ssf_sel(paddr, SSF_OFS_CONTROL)) begin
        serial_control_reg_r <= pwdata[1:0];
      end
      if (ssf_sel(paddr, SSF_OFS_MODE)) begin
        smartcard_select_r <= pwdata[SSF_B_SC_SEL];
      end
      if (ssf_sel(paddr, SSF_OFS_IRQ_MASK)) begin
        irq_mask_r <= pwdata[3:0];
      end
    end
  end

  assign tx_enable_bit = serial_control_reg_r[SSF_B_TX_EN];
  assign rx_enable_bit = serial_control_reg_r[SSF_B_RX_EN];

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  // writable multiprocessor bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_multiproc_bit_r <= SSF_RST_FLAG;
    end else if (wr_status) begin
      tx_multiproc_bit_r <= pwdata[SSF_B_TX_MPB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_reg_r <= SSF_RST_BYTE;
    end else if (dma_tx_wr) begin
      tx_data_reg_r <= dma_tx_data;
    end else if (wr && ssf_sel(paddr, SSF_OFS_TX_DATA)) begin
      tx_data_reg_r <= pwdata[7:0];
    end
  end

  assign tx_word = '{data: tx_data_reg_r, rx_multiproc_bit: tx_multiproc_bit_r};

  assign set_tx_empty = !tx_enable_bit || tx_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_flag_r <= SSF_RST_TX_EMPTY;
    end else if (set_tx_empty) begin
      tx_empty_flag_r <= 1'b1;
    end else if (clr_tx_empty) begin
      tx_empty_flag_r <= 1'b0;
    end
  end

  assign set_tx_end = !tx_enable_bit || (tx_last_bit && tx_empty_flag_r);
  // smart-card mode clears the end flag on tx_load
  // clears with empty flag, DMA write
  assign clr_tx_end = smartcard_select_r ? tx_load : clr_tx_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_end_flag_r <= SSF_RST_TX_END;
    end else if (set_tx_end) begin
      tx_end_flag_r <= 1'b1;
    end else if (clr_tx_end) begin
      tx_end_flag_r <= 1'b0;
    end
  end

  assign tx_irq = tx_enable_bit && tx_empty_flag_r;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  // any error flag stops reception
  assign rx_blocked = overrun_flag_r || parity_error_flag_r || framing_error_flag_r;
  assign rx_accept  = rx_done && !rx_blocked;
  assign rx_overrun = rx_accept && rx_full_flag_r;
  assign rx_bad     = rx_accept && !rx_full_flag_r && (rx_frame.parity_err || rx_frame.framing_err);
  assign rx_clean   = rx_accept && !rx_full_flag_r && !rx_frame.parity_err && !rx_frame.framing_err;

  // errored data still stored; old data kept on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg_r <= SSF_RST_BYTE;
    end else if (rx_accept && !rx_full_flag_r) begin
      rx_data_reg_r <= rx_frame.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_multiproc_bit_r <= SSF_RST_FLAG;
    end else if (rx_accept && !rx_full_flag_r) begin
      rx_multiproc_bit_r <= rx_frame.rx_multiproc_bit;
    end
  end

  // full set; clear; no enable term; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag_r <= SSF_RST_FLAG;
    end else if (rx_clean) begin
      rx_full_flag_r <= 1'b1;
    end else if (clr_rx_full) begin
      rx_full_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag_r       <= SSF_RST_FLAG;
      parity_error_flag_r  <= SSF_RST_FLAG;
      framing_error_flag_r <= SSF_RST_FLAG;
    end else begin
      if (rx_overrun) begin
        overrun_flag_r <= 1'b1;
      end else if (clr_overrun) begin
        overrun_flag_r <= 1'b0;
      end
      if (rx_bad && rx_frame.parity_err) begin
        parity_error_flag_r <= 1'b1;
      end else if (clr_parity) begin
        parity_error_flag_r <= 1'b0;
      end
      if (rx_bad && rx_frame.framing_err) begin
        framing_error_flag_r <= 1'b1;
      end else if (clr_framing) begin
        framing_error_flag_r <= 1'b0;
      end
    end
  end

  assign rx_irq = rx_full_flag_r;

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  logic [3:0] irq_set;
  assign irq_set = {set_tx_end && !tx_end_flag_r,
                    rx_overrun || rx_bad,
                    rx_clean,
                    set_tx_empty && !tx_empty_flag_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= SSF_RST_NIBBLE;
    end else begin
      irq_stat_r <= irq_set | (irq_stat_r &
                    ~((wr && ssf_sel(paddr, SSF_OFS_IRQ_STAT)) ? pwdata[3:0] : 4'h0));
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TX_END_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_enable_bit |=> tx_end_flag_r) else $error("end flag not set while disabled");

  AST_TX_END_FLAG_CLR_SW: assert property (@(posedge pclk) disable iff (!presetn)
    (!smartcard_select_r && wr_status && armed_r[SSF_B_TX_EMPTY] && !pwdata[SSF_B_TX_EMPTY] && !set_tx_end)
    |=> !tx_end_flag_r) else $error("end flag not cleared by zero write");

  AST_TX_END_FLAG_CLR_DMA: assert property (@(posedge pclk) disable iff (!presetn)
    (!smartcard_select_r && dma_tx_wr && !set_tx_end) |=> !tx_end_flag_r)
    else $error("end flag not cleared by DMA write");

  AST_RX_MPB: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && !rx_blocked && !rx_full_flag_r) |=> rx_multiproc_bit_r == $past(rx_frame.rx_multiproc_bit))
    else $error("receive multiprocessor bit not captured");

  AST_TX_MPB: assert property (@(posedge pclk) disable iff (!presetn)
    wr_status |=> tx_word.rx_multiproc_bit == $past(pwdata[SSF_B_TX_MPB]))
    else $error("transmit multiprocessor bit not applied");

  AST_W1_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[SSF_B_RX_FULL] && !rx_full_flag_r && !rx_clean) |=> !rx_full_flag_r)
    else $error("writing one set a flag");

  AST_TX_EMPTY_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    tx_load |=> tx_empty_flag_r) else $error("empty flag not set on load");

  AST_RX_FULL_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && !rx_blocked && !rx_full_flag_r && !rx_frame.parity_err && !rx_frame.framing_err)
    |=> rx_full_flag_r && rx_data_reg_r == $past(rx_frame.data)) else $error("clean reception lost");

  AST_RX_FULL_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_rx_rd && !rx_clean) |=> !rx_full_flag_r) else $error("full flag not cleared by DMA");

  AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && rx_full_flag_r && !rx_blocked) |=> overrun_flag_r && rx_blocked && $stable(rx_data_reg_r))
    else $error("overrun not flagged or data overwritten");

  AST_ERR_MOVE: assert property (@(posedge pclk) disable iff (!presetn)
    rx_bad |=> !rx_full_flag_r && rx_data_reg_r == $past(rx_frame.data))
    else $error("errored data handling wrong");

endmodule : ssf_status

// File: hdl/ssf_pkg.sv
// Package: register map, field positions, reset values and carriers of the serial status flags
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SSF_OFS_STATUS   = 8'h00;
  localparam logic [7:0] SSF_OFS_CONTROL  = 8'h04;
  localparam logic [7:0] SSF_OFS_MODE     = 8'h08;
  localparam logic [7:0] SSF_OFS_TX_DATA  = 8'h0C;
  localparam logic [7:0] SSF_OFS_RX_DATA  = 8'h10;
  localparam logic [7:0] SSF_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] SSF_OFS_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int SSF_B_TX_EMPTY = 7;
  localparam int SSF_B_RX_FULL  = 6;
  localparam int SSF_B_OVERRUN  = 5;
  localparam int SSF_B_FRAMING  = 4;
  localparam int SSF_B_PARITY   = 3;
  localparam int SSF_B_TX_END   = 2;
  localparam int SSF_B_RX_MPB   = 1;
  localparam int SSF_B_TX_MPB   = 0;

  // Control and mode fields
  localparam int SSF_B_TX_EN    = 0;
  localparam int SSF_B_RX_EN    = 1;
  localparam int SSF_B_SC_SEL   = 0;

  // Interrupt status / mask fields
  localparam int SSF_I_TX_EMPTY = 0;
  localparam int SSF_I_RX_FULL  = 1;
  localparam int SSF_I_ERROR    = 2;
  localparam int SSF_I_TX_END   = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       SSF_RST_TX_EMPTY = 1'b1;
  localparam logic       SSF_RST_TX_END   = 1'b1;
  localparam logic       SSF_RST_FLAG     = 1'b0;
  localparam logic [7:0] SSF_RST_BYTE     = 8'h00;
  localparam logic [3:0] SSF_RST_NIBBLE   = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       rx_multiproc_bit;
    logic       parity_err;
    logic       framing_err;
  } ssf_rx_frame_t;

  typedef struct packed {
    logic [7:0] data;
    logic       rx_multiproc_bit;
  } ssf_tx_word_t;

endpackage : ssf_pkg

// File: verif/ssf_line_model.sv
// Line-side partner: transmit shifter pulses and received frames
`timescale 1ns/1ns
module ssf_line_model
  import ssf_pkg::*;
(
  input  wire logic          pclk,
  input  wire ssf_tx_word_t  tx_word,
  output logic               tx_load,
  output logic               tx_last_bit,
  output logic               rx_done,
  output ssf_rx_frame_t      rx_frame
);
  ssf_tx_word_t sent;

  initial begin
    tx_load     = 1'b0;
    tx_last_bit = 1'b0;
    rx_done     = 1'b0;
    rx_frame    = '0;
    sent        = '0;
  end

  // Shifter takes the character; keep what would go on the line
  task automatic load_char();
    @(posedge pclk);
    tx_load <= 1'b1;
    @(posedge pclk);
    tx_load <= 1'b0;
    sent    <= tx_word;
  endtask : load_char

  task automatic last_bit();
    @(posedge pclk);
    tx_last_bit <= 1'b1;
    @(posedge pclk);
    tx_last_bit <= 1'b0;
  endtask : last_bit

  task automatic send_frame(input ssf_rx_frame_t f, input int gap = 0);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    rx_frame <= f;
    rx_done  <= 1'b1;
    @(posedge pclk);
    rx_done  <= 1'b0;
    // Stale frame lines must not look valid
    rx_frame <= ~f;
  endtask : send_frame
endmodule : ssf_line_model

// File: verif/ssf_status_tb.sv
// Testbench: APB and line-side scenarios for the serial status flags
`timescale 1ns/1ns
module ssf_status_tb
  import ssf_pkg::*;
;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} ssf_exp_t;

  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic          dma_tx_wr = 1'b0, dma_rx_rd = 1'b0;
  logic [7:0]    paddr = 8'h00, dma_tx_data = 8'h00, d;
  logic [31:0]   pwdata = 32'h0, prdata;
  logic          pready, pslverr, tx_load, tx_last_bit, tx_enable_bit, rx_done;
  logic          rx_enable_bit, rx_blocked, tx_irq, rx_irq, irq;
  ssf_tx_word_t  tx_word;
  ssf_rx_frame_t rx_frame, f;
  ssf_exp_t      expq[$];
  int            mismatches = 0, tests_run = 0, cycles = 0;

  ssf_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                  .tx_load, .tx_last_bit, .tx_word, .tx_enable_bit, .rx_done, .rx_frame, .rx_enable_bit,
                  .rx_blocked, .dma_tx_wr, .dma_tx_data, .dma_rx_rd, .tx_irq, .rx_irq, .irq);
  ssf_line_model model (.pclk, .tx_word, .tx_load, .tx_last_bit, .rx_done, .rx_frame);

  always #25 pclk = ~pclk;

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    apb(1'b1, a, dw);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic e = 1'b0);
    expq.push_back('{v, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic dma(input logic t, input logic [7:0] dd);
    @(posedge pclk);
    dma_tx_wr   <= t;
    dma_rx_rd   <= !t;
    dma_tx_data <= dd;
    @(posedge pclk);
    dma_tx_wr   <= 1'b0;
    dma_rx_rd   <= 1'b0;
    dma_tx_data <= ~dd;
  endtask : dma

  task automatic bit_chk(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : bit_chk

  // ----------------------------------------------------------------
  // Read monitor: oldest note against each completed read
  // ----------------------------------------------------------------
  always @(posedge pclk) begin : mon
    ssf_exp_t x;
    if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
      x = expq.pop_front();
      chk("prdata", x.v & x.m, prdata & x.m);
      bit_chk("pslverr", x.e, pslverr);
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h137d9bb8));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(SSF_OFS_STATUS, 32'h84);
    rd(SSF_OFS_RX_DATA, 32'h0);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(SSF_OFS_STATUS, 32'hFF);
    rd(SSF_OFS_STATUS, 32'h85);
    model.load_char();
    wr(SSF_OFS_STATUS, 32'h00);
    bit_chk("sent mpb", 1'b1, model.sent.rx_multiproc_bit);
    rd(SSF_OFS_STATUS, 32'h84);
    // Normal mode transmit
    wr(SSF_OFS_CONTROL, 32'h3);
    @(negedge pclk);
    bit_chk("tx_irq", 1'b1, tx_irq);
    bit_chk("tx_enable_bit", 1'b1, tx_enable_bit);
    bit_chk("rx_enable_bit", 1'b1, rx_enable_bit);
    rd(SSF_OFS_STATUS, 32'h84);
    wr(SSF_OFS_STATUS, 32'h00);
    rd(SSF_OFS_STATUS, 32'h00);
    d = 8'($urandom);
    wr(SSF_OFS_TX_DATA, {24'h0, d});
    model.load_char();
    model.last_bit();
    chk("sent data", {24'h0, d}, {24'h0, model.sent.data});
    rd(SSF_OFS_STATUS, 32'h84);
    rd(SSF_OFS_IRQ_STAT, 32'h9);
    wr(SSF_OFS_IRQ_STAT, 32'hF);
    d = 8'($urandom);
    dma(1'b1, d);
    @(negedge pclk);
    chk("tx data", {24'h0, d}, {24'h0, tx_word.data});
    bit_chk("tx_irq", 1'b0, tx_irq);
    rd(SSF_OFS_STATUS, 32'h00);
    model.last_bit();
    rd(SSF_OFS_STATUS, 32'h00);
    model.load_char();
    rd(SSF_OFS_STATUS, 32'h80);
    // Hardware set lands on the clearing write's edge
    fork
      wr(SSF_OFS_STATUS, 32'h00);
      begin
        @(posedge pclk);
        model.load_char();
      end
    join
    rd(SSF_OFS_STATUS, 32'h80);
    // Smart-card interpretation
    wr(SSF_OFS_MODE, 32'h1);
    model.last_bit();
    rd(SSF_OFS_STATUS, 32'h84);
    wr(SSF_OFS_STATUS, 32'h00);
    rd(SSF_OFS_STATUS, 32'h04);
    model.load_char();
    rd(SSF_OFS_STATUS, 32'h80);
    dma(1'b1, 8'h3C);
    rd(SSF_OFS_STATUS, 32'h00);
    wr(SSF_OFS_MODE, 32'h0);
    // Receive path and interrupt
    wr(SSF_OFS_IRQ_STAT, 32'hF);
    wr(SSF_OFS_IRQ_MASK, 32'h2);
    f = '{8'($urandom), 1'b1, 1'b0, 1'b0};
    model.send_frame(f, 3);
    @(negedge pclk);
    bit_chk("rx_irq", 1'b1, rx_irq);
    rd(SSF_OFS_STATUS, 32'h42);
    rd(SSF_OFS_RX_DATA, {24'h0, f.data});
    rd(SSF_OFS_IRQ_STAT, 32'h2, 32'h2);
    @(negedge pclk);
    bit_chk("irq", 1'b1, irq);
    model.send_frame('{8'($urandom), 1'b0, 1'b0, 1'b0});
    rd(SSF_OFS_STATUS, 32'h62);
    rd(SSF_OFS_RX_DATA, {24'h0, f.data});
    model.send_frame('{8'($urandom), 1'b0, 1'b1, 1'b0});
    @(negedge pclk);
    bit_chk("rx_blocked", 1'b1, rx_blocked);
    wr(SSF_OFS_STATUS, 32'hFE);
    wr(SSF_OFS_STATUS, 32'h00);
    rd(SSF_OFS_STATUS, 32'h62);
    wr(SSF_OFS_STATUS, 32'h40);
    rd(SSF_OFS_STATUS, 32'h42);
    wr(SSF_OFS_CONTROL, 32'h1);
    @(negedge pclk);
    bit_chk("rx_enable_bit", 1'b0, rx_enable_bit);
    bit_chk("tx_enable_bit", 1'b1, tx_enable_bit);
    rd(SSF_OFS_STATUS, 32'h42);
    dma(1'b0, 8'h00);
    rd(SSF_OFS_STATUS, 32'h02);
    wr(SSF_OFS_IRQ_STAT, 32'hF);
    @(negedge pclk);
    bit_chk("irq", 1'b0, irq);
    // Error frames: data moves, full flag stays low, masked interrupt
    for (int k = 0; k < 2; k++) begin
      f = '{8'($urandom), 1'b0, k == 0, k == 1};
      model.send_frame(f);
      rd(SSF_OFS_RX_DATA, {24'h0, f.data});
      rd(SSF_OFS_STATUS, k == 0 ? 32'h08 : 32'h10);
      @(negedge pclk);
      bit_chk("irq", 1'b0, irq);
      wr(SSF_OFS_STATUS, 32'h00);
      rd(SSF_OFS_STATUS, 32'h00);
    end
    model.send_frame('{8'h5A, 1'b0, 1'b0, 1'b0});
    rd(SSF_OFS_STATUS, 32'h40);
    wr(SSF_OFS_STATUS, 32'h00);
    rd(SSF_OFS_STATUS, 32'h00);
    repeat (2) @(posedge pclk);
    chk("pending reads", 32'h0, 32'(expq.size()));
    results();
  end
endmodule : ssf_status_tb
